//--- src/swc_pkg.sv
// package: command codes, field positions, reset values, timing for the switch config block
package swc_pkg;

  // ==========================================
  // frame layout
  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned CMD_MSB      = 23;
  localparam int unsigned CMD_LSB      = 16;
  localparam int unsigned NUM_PROG     = 8;
  localparam int unsigned NUM_GND      = 14;
  localparam int unsigned NUM_INPUTS   = 22;
  localparam int unsigned CUR_MSB      = 6;
  localparam int unsigned CUR_LSB      = 5;
  localparam int unsigned CHAN_MSB     = 4;
  localparam int unsigned CHAN_LSB     = 0;

  // ==========================================
  // command bytes
  localparam logic [7:0] CMD_ANALOG     = 8'h06;
  localparam logic [7:0] CMD_TMR_PROG   = 8'h07;
  localparam logic [7:0] CMD_TMR_GND    = 8'h08;
  localparam logic [7:0] CMD_HIZ_PROG   = 8'h09;
  localparam logic [7:0] CMD_HIZ_GND    = 8'h0A;
  localparam logic [7:0] CMD_RESET      = 8'h7F;

  // ==========================================
  // reset values
  localparam logic [7:0]  RST_TMR_PROG  = 8'hFF;
  localparam logic [13:0] RST_TMR_GND   = 14'h3FFF;
  localparam logic [7:0]  RST_HIZ_PROG  = 8'hFF;
  localparam logic [13:0] RST_HIZ_GND   = 14'h3FFF;
  localparam logic [4:0]  RST_CHAN      = 5'h00;
  localparam logic [1:0]  RST_CUR       = 2'h0;

  // ==========================================
  // analog channel map
  localparam logic [4:0] CHAN_NONE      = 5'h00;
  localparam logic [4:0] CHAN_GND_FIRST = 5'h01;
  localparam logic [4:0] CHAN_PRG_FIRST = 5'h0F;
  localparam logic [4:0] CHAN_PRG_LAST  = 5'h16;

  // ==========================================
  // timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned WET_TIME_MS    = 20;
  localparam int unsigned WET_CYCLES     = CLK_HZ / 1000 * WET_TIME_MS;

  // ==========================================
  // types
  typedef enum logic [1:0] {
    SWC_CUR_HIZ,
    SWC_CUR_LOW,
    SWC_CUR_HIGH,
    SWC_CUR_BAD
  } swc_cur_t;

  // per-input drive to the analog current sources
  typedef struct packed {
    logic [NUM_INPUTS-1:0] src_off;    // current source off
    logic [NUM_INPUTS-1:0] high_cur;   // 16 mA when set, else 2.0 mA
    logic [NUM_INPUTS-1:0] pull_up;    // pull-up direction forced
  } swc_drive_t;

  typedef struct packed {
    logic [4:0] chan;
    logic [1:0] cur;
  } swc_analog_t;

endpackage : swc_pkg

//--- src/swc_cfg.sv
// switch input configuration: serial command decode, wetting timers, high-z, analog select
`timescale 1ns/1ps

// How it works
// - each input has a 20 ms timer started when its comparator rises past threshold.
// - on timer expiry the input drops from 16 mA to 2.0 mA.
// - with timer disabled a closed input keeps 16 mA indefinitely.
// - timer enable bit 0 disables, 1 enables.
// - command 07 loads programmable timer enables, 08 loads ground timer enables.
// - timer, high-z and analog registers may be written any time in normal mode.
// - high-z bit 1 turns the current source off, overriding metallic setting; the analog-selected input follows the analog current code instead.
// - comparators keep working and reporting while an input is high-z.
// - command 09 loads programmable high-z, 0A loads ground high-z.
// - channel select routes one of 22 inputs, or none, to analog output.
// - the selected analog input reads as 0 in the next status response.
// - current code 00 high-z, 01 2.0 mA, 10 16 mA, 11 high-z.
// - analog currents are always pull-ups, never pull-down on programmable inputs.
// - channel 0 none, 1..14 ground inputs, 15..22 programmable inputs.
// - command 06 is analog; bits 6:5 current, bits 4:0 channel.
// - reset or reset command enables timers, sets all high-z, channel zero.
// - writes accepted only in normal mode with logic supply present.
module swc_cfg #(
  parameter int unsigned WET_CYCLES = swc_pkg::WET_CYCLES  // wetting time in clocks
) (
  input  wire logic                              clk_i,          // 25 MHz clock
  input  wire logic                              rst_n_i,        // async reset, low
  input  wire logic                              sclk_i,         // serial clock pin
  input  wire logic                              cs_n_i,         // chip select pin, low
  input  wire logic                              si_i,           // serial data in pin
  input  wire logic                              normal_mode_i,  // device in normal mode
  input  wire logic                              logic_pwr_i,    // logic supply present
  input  wire logic [swc_pkg::NUM_INPUTS-1:0]    comp_i,         // comparator outputs
  output logic      [swc_pkg::NUM_INPUTS-1:0]    status_o,       // switch status to report
  output swc_pkg::swc_drive_t                    drive_o,        // current source controls
  output logic      [swc_pkg::NUM_INPUTS-1:0]    analog_buffered_output_sel_o,     // analog mux one-hot
  output logic                                   analog_buffered_output_en_o       // analog output active
);

  localparam int unsigned NI = swc_pkg::NUM_INPUTS;
  localparam int unsigned NG = swc_pkg::NUM_GND;
  localparam int unsigned NP = swc_pkg::NUM_PROG;
  localparam int unsigned CW = $clog2(WET_CYCLES + 1);

  // ==========================================
  // pin synchronisers
  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [2:0] si_q;
  logic [NI-1:0] comp_s1_q;
  logic [NI-1:0] comp_s2_q;
  logic [NI-1:0] comp_s3_q;
  logic [NI-1:0] comp_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_q    <= 3'h0;
      cs_q      <= 3'h7;
      si_q      <= 3'h0;
      comp_s1_q <= '0;
      comp_s2_q <= '0;
      comp_s3_q <= '0;
    end
    else
    begin
      sclk_q    <= {sclk_q[1:0], sclk_i};
      cs_q      <= {cs_q[1:0], cs_n_i};
      si_q      <= {si_q[1:0], si_i};
      comp_s1_q <= comp_i;
      comp_s2_q <= comp_s1_q;
      comp_s3_q <= comp_s2_q;
    end
  end

  // a level counts once stages two and three agree; otherwise hold the last value
  logic sclk_lvl_q;
  logic cs_lvl_q;
  logic sclk_lvl_d;
  logic cs_lvl_d;
  logic [NI-1:0] comp_d;

  assign sclk_lvl_d = (sclk_q[1] == sclk_q[2]) ? sclk_q[2] : sclk_lvl_q;
  assign cs_lvl_d   = (cs_q[1] == cs_q[2]) ? cs_q[2] : cs_lvl_q;
  assign comp_d     = (comp_s2_q & comp_s3_q) | (comp_q & (comp_s2_q | comp_s3_q));

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_lvl_q <= 1'b0;
      cs_lvl_q   <= 1'b1;
      comp_q     <= '0;
    end
    else
    begin
      sclk_lvl_q <= sclk_lvl_d;
      cs_lvl_q   <= cs_lvl_d;
      comp_q     <= comp_d;
    end
  end

  wire sclk_rise = sclk_lvl_d & ~sclk_lvl_q;
  wire cs_fall   = ~cs_lvl_d & cs_lvl_q;
  wire cs_rise   = cs_lvl_d & ~cs_lvl_q;

  // ==========================================
  // frame shifter
  logic [swc_pkg::FRAME_BITS-1:0] shift_q;
  logic [4:0]                     bits_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shift_q <= '0;
      bits_q  <= 5'h00;
    end
    else if (cs_fall)
    begin
      shift_q <= '0;
      bits_q  <= 5'h00;
    end
    else if (!cs_lvl_q && sclk_rise)
    begin
      shift_q <= {shift_q[swc_pkg::FRAME_BITS-2:0], si_q[2]};
      bits_q  <= (bits_q == 5'h1F) ? bits_q : bits_q + 5'h01;
    end
  end

  // ==========================================
  // command decode
  // short or long frames are dropped; a daisy chain must still deliver 24 bits here
  wire [7:0] cmd_byte = shift_q[swc_pkg::CMD_MSB:swc_pkg::CMD_LSB];
  wire       frame_ok = (bits_q == 5'(swc_pkg::FRAME_BITS));
  wire       wr_ok    = normal_mode_i & logic_pwr_i;
  wire       apply    = cs_rise & frame_ok & wr_ok;
  // writes taken only on a full frame in normal mode with logic supply present
  wire       wr_tmr_p = apply & (cmd_byte == swc_pkg::CMD_TMR_PROG);
  wire       wr_tmr_g = apply & (cmd_byte == swc_pkg::CMD_TMR_GND);
  wire       wr_hiz_p = apply & (cmd_byte == swc_pkg::CMD_HIZ_PROG);
  wire       wr_hiz_g = apply & (cmd_byte == swc_pkg::CMD_HIZ_GND);
  wire       wr_ana   = apply & (cmd_byte == swc_pkg::CMD_ANALOG);
  wire       wr_rst   = apply & (cmd_byte == swc_pkg::CMD_RESET);

  // ==========================================
  // configuration registers
  logic [NP-1:0]        tmr_en_p_q;
  logic [NG-1:0]        tmr_en_g_q;
  logic [NP-1:0]        hiz_p_q;
  logic [NG-1:0]        hiz_g_q;
  swc_pkg::swc_analog_t ana_q;

  // defaults on reset and reset command
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tmr_en_p_q <= swc_pkg::RST_TMR_PROG;
      tmr_en_g_q <= swc_pkg::RST_TMR_GND;
      hiz_p_q    <= swc_pkg::RST_HIZ_PROG;
      hiz_g_q    <= swc_pkg::RST_HIZ_GND;
      ana_q      <= '{chan: swc_pkg::RST_CHAN, cur: swc_pkg::RST_CUR};
    end
    else if (wr_rst)
    begin
      tmr_en_p_q <= swc_pkg::RST_TMR_PROG;
      tmr_en_g_q <= swc_pkg::RST_TMR_GND;
      hiz_p_q    <= swc_pkg::RST_HIZ_PROG;
      hiz_g_q    <= swc_pkg::RST_HIZ_GND;
      ana_q      <= '{chan: swc_pkg::RST_CHAN, cur: swc_pkg::RST_CUR};
    end
    else
    begin
      if (wr_tmr_p) tmr_en_p_q <= shift_q[NP-1:0];
      if (wr_tmr_g) tmr_en_g_q <= shift_q[NG-1:0];
      if (wr_hiz_p) hiz_p_q    <= shift_q[NP-1:0];
      if (wr_hiz_g) hiz_g_q    <= shift_q[NG-1:0];
      // current and channel come together in one frame
      if (wr_ana)
      begin
        ana_q.chan <= shift_q[swc_pkg::CHAN_MSB:swc_pkg::CHAN_LSB];
        ana_q.cur  <= shift_q[swc_pkg::CUR_MSB:swc_pkg::CUR_LSB];
      end
    end
  end

  // input vector order: ground inputs in bits 13:0, programmable in 21:14
  wire [NI-1:0] tmr_en = {tmr_en_p_q, tmr_en_g_q};
  wire [NI-1:0] hiz    = {hiz_p_q, hiz_g_q};

  // ==========================================
  // analog channel decode
  // channel code to one-hot
  function automatic logic [NI-1:0] chan_onehot(input logic [4:0] code);
    logic [NI-1:0] oh;
    oh = '0;
    if (code >= swc_pkg::CHAN_GND_FIRST && code <= swc_pkg::CHAN_PRG_LAST)
      oh[code - swc_pkg::CHAN_GND_FIRST] = 1'b1;
    return oh;
  endfunction : chan_onehot

  wire [NI-1:0] sel_oh = chan_onehot(ana_q.chan);
  wire          sel_any = |sel_oh;

  swc_pkg::swc_cur_t ana_cur;
  assign ana_cur = swc_pkg::swc_cur_t'(ana_q.cur);
  wire ana_hiz  = (ana_cur == swc_pkg::SWC_CUR_HIZ) | (ana_cur == swc_pkg::SWC_CUR_BAD);
  wire ana_high = (ana_cur == swc_pkg::SWC_CUR_HIGH);

  // ==========================================
  // wetting timers
  logic [CW-1:0] wet_cnt_q [NI];
  logic [NI-1:0] wet_run_q;
  logic [NI-1:0] wet_done_q;
  wire  [NI-1:0] comp_rise = comp_d & ~comp_q;

  for (genvar i = 0; i < NI; i++)
  begin : g_wet
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        wet_cnt_q[i]  <= '0;
        wet_run_q[i]  <= 1'b0;
        wet_done_q[i] <= 1'b0;
      end
      else if (comp_rise[i])
      begin
        wet_cnt_q[i]  <= CW'(WET_CYCLES - 1);
        wet_run_q[i]  <= 1'b1;
        wet_done_q[i] <= 1'b0;
      end
      else if (!comp_q[i])
      begin
        wet_run_q[i]  <= 1'b0;
        wet_done_q[i] <= 1'b0;
      end
      else if (wet_run_q[i])
      begin
        if (wet_cnt_q[i] == '0)
        begin
          wet_run_q[i]  <= 1'b0;
          wet_done_q[i] <= 1'b1;
        end
        else
          wet_cnt_q[i] <= wet_cnt_q[i] - CW'(1);
      end
    end
  end

  // ==========================================
  // current source drive
  // expired and enabled timer gives low current
  wire [NI-1:0] metal_high = ~(wet_done_q & tmr_en);
  wire [NI-1:0] norm_off   = hiz;

  swc_pkg::swc_drive_t drive_d;
  always_comb
  begin
    drive_d.src_off  = sel_any ? ((norm_off & ~sel_oh) | (sel_oh & {NI{ana_hiz}})) : norm_off;
    drive_d.high_cur = sel_any ? ((metal_high & ~sel_oh) | (sel_oh & {NI{ana_high}}))
                               : metal_high;
    // selected analog input is always a pull-up
    drive_d.pull_up  = sel_oh;
  end

  wire [NI-1:0] status_d = comp_q & ~sel_oh;

  // ==========================================
  // registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      drive_o    <= '{src_off: '1, high_cur: '1, pull_up: '0};
      analog_buffered_output_sel_o <= '0;
      analog_buffered_output_en_o  <= 1'b0;
      status_o   <= '0;
    end
    else
    begin
      drive_o    <= drive_d;
      analog_buffered_output_sel_o <= sel_oh;
      analog_buffered_output_en_o  <= sel_any;
      status_o   <= status_d;
    end
  end

endmodule : swc_cfg

//--- tb/swc_cfg_props.sv
// checker: port relations of the switch config block
`timescale 1ns/1ps
module swc_cfg_props #(
  parameter int unsigned WET_CYCLES = swc_pkg::WET_CYCLES  // wetting clocks
) (
  input wire logic                clk_i,          // clock
  input wire logic                rst_n_i,        // reset, low
  input wire logic                cs_n_i,         // select, low
  input wire logic                normal_mode_i,  // normal mode
  input wire logic [21:0]         comp_i,         // comparators
  input wire logic [21:0]         status_o,       // status
  input wire swc_pkg::swc_drive_t drive_o,        // drive
  input wire logic [21:0]         analog_buffered_output_sel_o,     // mux select
  input wire logic                analog_buffered_output_en_o       // mux active
);
  // ======
  // helper: clocks that ground input 0 has been high
  logic [31:0] hi_cnt_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i) hi_cnt_q <= '0;
    else if (comp_i[0]) hi_cnt_q <= hi_cnt_q + 32'h1;
    else hi_cnt_q <= '0;
  end
  // ======
  // properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sel_onehot_a: assert property ($onehot0(analog_buffered_output_sel_o))
    else $error("mux select not one-hot");
  en_match_a: assert property (analog_buffered_output_en_o == (analog_buffered_output_sel_o != '0))
    else $error("mux enable disagrees with select");
  status_mask_a: assert property ((status_o & analog_buffered_output_sel_o) == '0)
    else $error("selected input reported closed");
  pull_up_a: assert property ((drive_o.pull_up & analog_buffered_output_sel_o) == analog_buffered_output_sel_o)
    else $error("selected input not pulled up");
  // an update lands a few clocks after select rises, so 8 low clocks means settled
  idle_hold_a: assert property (!cs_n_i [*8] |->
    $stable(analog_buffered_output_sel_o) && $stable(drive_o.src_off))
    else $error("config changed inside a frame");
  mode_gate_a: assert property (!normal_mode_i [*8] |-> $stable(drive_o.src_off))
    else $error("config changed outside normal mode");
  rst_val_a: assert property ($rose(rst_n_i) |-> &drive_o.src_off && &drive_o.high_cur && !analog_buffered_output_en_o)
    else $error("wrong values after reset");
  wet_time_a: assert property ($fell(drive_o.high_cur[0]) && !analog_buffered_output_sel_o[0]
    |-> hi_cnt_q >= WET_CYCLES)
    else $error("wetting current cut early");
  cover property (analog_buffered_output_en_o);
  cover property ($fell(drive_o.high_cur[0]));
  cover property (drive_o.src_off == '0);
endmodule : swc_cfg_props

bind swc_cfg swc_cfg_props #(.WET_CYCLES(WET_CYCLES)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .normal_mode_i(normal_mode_i),
  .comp_i(comp_i), .status_o(status_o), .drive_o(drive_o), .analog_buffered_output_sel_o(analog_buffered_output_sel_o),
  .analog_buffered_output_en_o(analog_buffered_output_en_o));

//--- tb/swc_spi_host.sv
// partner: serial controller sending command frames
`timescale 1ns/1ps
module swc_spi_host (
  input  wire logic clk_i,   // block clock
  output logic      sclk_o,  // serial clock
  output logic      cs_n_o,  // select, low
  output logic      si_o     // serial data
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // half of a 320 ns serial period
  task automatic half;
    repeat (4) @(negedge clk_i);
  endtask : half
  // msb first; the clock stands still between frames
  task automatic send(input logic [23:0] frame, input int nbits);
    cs_n_o = 1'b0;
    half();
    for (int i = nbits - 1; i >= 0; i--)
    begin
      si_o = frame[i];
      half();
      sclk_o = 1'b1;
      half();
      sclk_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    // released data line must not keep its last value
    si_o = ~si_o;
    repeat (2) half();
  endtask : send
endmodule : swc_spi_host

//--- tb/swc_cfg_tb.sv
// testbench: command frames in, drive and mux outputs checked
`timescale 1ns/1ps
module swc_cfg_tb;
  localparam int unsigned WET = 50;
  localparam logic [21:0] ONES = '1;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sclk_i, cs_n_i, si_i;
  logic normal_mode_i = 1'b1;
  logic logic_pwr_i = 1'b1;
  logic [21:0] comp_i = '0;
  logic [21:0] status_o, analog_buffered_output_sel_o, hz, sel, es, eh;
  logic [1:0] cur;
  logic analog_buffered_output_en_o;
  swc_pkg::swc_drive_t drive_o;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  always #20 clk_i = ~clk_i;

  swc_cfg #(.WET_CYCLES(WET)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .normal_mode_i(normal_mode_i), .logic_pwr_i(logic_pwr_i), .comp_i(comp_i),
    .status_o(status_o), .drive_o(drive_o), .analog_buffered_output_sel_o(analog_buffered_output_sel_o), .analog_buffered_output_en_o(analog_buffered_output_en_o));
  swc_spi_host u_host (.clk_i(clk_i), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));

  // ======
  // compare and report
  task automatic chk(input string name, input logic [21:0] exp, input logic [21:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : chk
  task automatic chk_all(input logic [21:0] src, input logic [21:0] hic, input logic [21:0] s);
    chk("src_off", src, drive_o.src_off);
    chk("high_cur", hic, drive_o.high_cur);
    chk("analog_buffered_output_sel", s, analog_buffered_output_sel_o);
    chk("analog_buffered_output_en", {21'h0, s != '0}, {21'h0, analog_buffered_output_en_o});
    chk("pull_up", s, drive_o.pull_up);
    chk("status", comp_i & ~s, status_o);
  endtask : chk_all
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // a hung handshake ends the run as a mismatch
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 15000)
    begin
      bad_count++;
      end_sim();
    end
  end

  // ======
  // tests
  initial
  begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    chk_all(ONES, ONES, '0);
    $display("test reset done");
    u_host.send({swc_pkg::CMD_HIZ_GND, 16'hD555}, 24);
    u_host.send({swc_pkg::CMD_HIZ_PROG, 16'hFF3C}, 24);
    hz = {8'h3C, 14'h1555};
    chk_all(hz, ONES, '0);
    $display("test highz done");
    // short frame, mode off, supply off, unknown command
    for (int k = 0; k < 4; k++)
    begin
      normal_mode_i = (k != 1);
      logic_pwr_i = (k != 2);
      u_host.send({(k == 3) ? 8'h0B : swc_pkg::CMD_HIZ_GND, 16'h0}, (k == 0) ? 23 : 24);
      chk_all(hz, ONES, '0);
    end
    $display("test refuse done");
    u_host.send({swc_pkg::CMD_TMR_GND, 16'hC000}, 24);
    u_host.send({swc_pkg::CMD_TMR_PROG, 16'hFF00}, 24);
    comp_i = ONES;
    for (int c = 0; c < 32; c++)
    begin
      cur = c[1:0];
      sel = (c >= 1 && c <= 22) ? 22'h1 << (c - 1) : '0;
      es = (hz & ~sel) | (sel & {22{cur == 2'h0 || cur == 2'h3}});
      eh = ~sel | (sel & {22{cur == 2'h2}});
      u_host.send({swc_pkg::CMD_ANALOG, 9'h1FF, cur, c[4:0]}, 24);
      chk_all(es, eh, sel);
    end
    $display("test analog done");
    comp_i = '0;
    u_host.send({swc_pkg::CMD_TMR_GND, 16'h0005}, 24);
    u_host.send({swc_pkg::CMD_TMR_PROG, 16'h0080}, 24);
    comp_i = ONES;
    repeat (WET - 5) @(negedge clk_i);
    chk("wet_early", ONES, drive_o.high_cur);
    repeat (20) @(negedge clk_i);
    chk("wet_late", ~22'h200005, drive_o.high_cur);
    u_host.send({swc_pkg::CMD_TMR_GND, 16'h0000}, 24);
    chk("wet_off", ~22'h200000, drive_o.high_cur);
    $display("test wetting done");
    u_host.send({swc_pkg::CMD_ANALOG, 9'h0, 2'h2, 5'h16}, 24);
    chk_all(hz, ONES, 22'h200000);
    comp_i = '0;
    u_host.send({swc_pkg::CMD_RESET, 16'h0000}, 24);
    chk_all(ONES, ONES, '0);
    comp_i = ONES;
    repeat (WET + 15) @(negedge clk_i);
    chk("wet_reset", '0, drive_o.high_cur);
    $display("test reset_cmd done");
    end_sim();
  end
endmodule : swc_cfg_tb
